// >>> core/fhm_monitor.sv
module fhm_monitor #(
  parameter int TICK_CYCLES = fhm_pkg::FHM_TICK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Live drive measurements
  input wire logic [15:0] phase_current_in,
  input wire logic [15:0] link_voltage_in,
  input wire logic [15:0] stage_temp_in,
  input wire logic [15:0] motor_speed_in,
  input wire logic [15:0] current_u_in,
  input wire logic [15:0] current_v_in,
  input wire logic [fhm_pkg::FHM_DIN_N-1:0] digital_input_line_in,
  input wire logic [fhm_pkg::FHM_DOUT_N-1:0] digital_output_line_in,
  // Position increments
  input wire logic signed [15:0] ref_delta_in,
  input wire logic signed [15:0] fb_delta_in,
  // Fault event
  input wire logic fault_in,
  input wire logic [15:0] fault_code_in
);
  import fhm_pkg::*;

  logic [15:0] select_ff;
  logic [31:0] power_on_time;
  logic [31:0] position_error;
  logic [FHM_SNAP_W-1:0] snap;
  logic [FHM_SNAP_W-1:0] sel_data;
  logic [31:0] nxt_rdata;
  logic mapped;
  logic wr_en;
  logic rd_en;

  fhm_counters #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_counters (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .ref_delta_in(ref_delta_in),
    .fb_delta_in(fb_delta_in),
    .power_on_time_out(power_on_time),
    .position_error_out(position_error)
  );

  // Every field lands in one word so one push captures a coherent snapshot
  assign snap = {digital_output_line_in, digital_input_line_in, link_voltage_in,
                 current_v_in, current_u_in, motor_speed_in, power_on_time,
                 fault_code_in};

  fhm_history_mem #(
    .WIDTH(FHM_SNAP_W),
    .DEPTH(FHM_DEPTH),
    .SEL_W(FHM_SEL_W)
  ) u_mem (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .push_in(fault_in),
    .push_data_in(snap),
    .rd_sel_in(select_ff[FHM_SEL_W-1:0]),
    .rd_data_out(sel_data)
  );

  // Single access phase: zero wait states
  assign pready_out = 1'b1;
  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && !penable_in && !pwrite_in;

  always_comb begin
    mapped = 1'b1;
    nxt_rdata = 32'h0000_0000;
    unique case (paddr_in)
      FHM_OFS_POWER_ON_TIME: nxt_rdata = power_on_time;
      FHM_OFS_PHASE_CURRENT_RMS: nxt_rdata = {16'h0000, phase_current_in};
      FHM_OFS_DC_LINK_VOLTAGE: nxt_rdata = {16'h0000, link_voltage_in};
      FHM_OFS_POWER_STAGE_TEMP: nxt_rdata = {16'h0000, stage_temp_in};
      FHM_OFS_HISTORY_SELECT: nxt_rdata = {16'h0000, select_ff};
      FHM_OFS_HISTORY_FAULT_CODE: begin
        nxt_rdata = {16'h0000, sel_data[FHM_POS_CODE +: 16]};
      end
      FHM_OFS_HISTORY_TIME_STAMP: nxt_rdata = sel_data[FHM_POS_STAMP +: 32];
      FHM_OFS_HISTORY_SPEED: begin
        nxt_rdata = {16'h0000, sel_data[FHM_POS_SPEED +: 16]};
      end
      FHM_OFS_HISTORY_CURRENT_U: begin
        nxt_rdata = {16'h0000, sel_data[FHM_POS_IU +: 16]};
      end
      FHM_OFS_HISTORY_CURRENT_V: begin
        nxt_rdata = {16'h0000, sel_data[FHM_POS_IV +: 16]};
      end
      FHM_OFS_HISTORY_LINK_VOLTAGE: begin
        nxt_rdata = {16'h0000, sel_data[FHM_POS_VBUS +: 16]};
      end
      FHM_OFS_HISTORY_INPUT_LEVELS: begin
        nxt_rdata = {27'h0, sel_data[FHM_POS_DI +: FHM_DIN_N]};
      end
      FHM_OFS_HISTORY_OUTPUT_LEVELS: begin
        nxt_rdata = {29'h0, sel_data[FHM_POS_DO +: FHM_DOUT_N]};
      end
      FHM_OFS_POSITION_ERROR_COUNT: nxt_rdata = position_error;
      default: mapped = 1'b0;
    endcase
  end

  // Out of range selections are refused so the view stays on a real entry
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      select_ff <= FHM_SELECT_RST;
    end else if (wr_en && paddr_in == FHM_OFS_HISTORY_SELECT
                 && pwdata_in[15:0] <= FHM_SELECT_MAX && pwdata_in[31:16] == 16'h0000) begin
      select_ff <= pwdata_in[15:0];
    end
  end

  // Data latched in setup so it is a flop output during the access phase
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prdata_out <= '0;
    end else if (rd_en) begin
      prdata_out <= nxt_rdata;
    end
  end

  always_comb begin
    pslverr_out = psel_in && penable_in && !mapped;
  end
endmodule : fhm_monitor

// >>> core/fhm_pkg.sv
package fhm_pkg;
  localparam int FHM_DEPTH = 10;
  localparam int FHM_SEL_W = 4;
  localparam int FHM_DIN_N = 5;
  localparam int FHM_DOUT_N = 3;
  // Snapshot word: code16, stamp32, speed16, iu16, iv16, vbus16, di5, do3
  localparam int FHM_SNAP_W = 16 + 32 + 16 + 16 + 16 + 16 + FHM_DIN_N + FHM_DOUT_N;
  localparam int FHM_POS_CODE = 0;
  localparam int FHM_POS_STAMP = 16;
  localparam int FHM_POS_SPEED = 48;
  localparam int FHM_POS_IU = 64;
  localparam int FHM_POS_IV = 80;
  localparam int FHM_POS_VBUS = 96;
  localparam int FHM_POS_DI = 112;
  localparam int FHM_POS_DO = 117;
  // Register byte offsets
  localparam logic [7:0] FHM_OFS_POWER_ON_TIME = 8'h00;
  localparam logic [7:0] FHM_OFS_PHASE_CURRENT_RMS = 8'h04;
  localparam logic [7:0] FHM_OFS_DC_LINK_VOLTAGE = 8'h08;
  localparam logic [7:0] FHM_OFS_POWER_STAGE_TEMP = 8'h0c;
  localparam logic [7:0] FHM_OFS_HISTORY_SELECT = 8'h10;
  localparam logic [7:0] FHM_OFS_HISTORY_FAULT_CODE = 8'h14;
  localparam logic [7:0] FHM_OFS_HISTORY_TIME_STAMP = 8'h18;
  localparam logic [7:0] FHM_OFS_HISTORY_SPEED = 8'h1c;
  localparam logic [7:0] FHM_OFS_HISTORY_CURRENT_U = 8'h20;
  localparam logic [7:0] FHM_OFS_HISTORY_CURRENT_V = 8'h24;
  localparam logic [7:0] FHM_OFS_HISTORY_LINK_VOLTAGE = 8'h28;
  localparam logic [7:0] FHM_OFS_HISTORY_INPUT_LEVELS = 8'h2c;
  localparam logic [7:0] FHM_OFS_HISTORY_OUTPUT_LEVELS = 8'h30;
  localparam logic [7:0] FHM_OFS_POSITION_ERROR_COUNT = 8'h34;
  localparam logic [15:0] FHM_SELECT_RST = 16'h0000;
  localparam logic [15:0] FHM_SELECT_MAX = 16'h0009;
  // One power-on time unit is 0.1 s
  localparam int FHM_TICK_NS = 100_000_000;
  localparam int FHM_CLK_NS = 40;
  localparam int FHM_TICK_CYCLES = FHM_TICK_NS / FHM_CLK_NS;
endpackage : fhm_pkg

// >>> core/fhm_history_mem.sv
module fhm_history_mem #(
  parameter int WIDTH = fhm_pkg::FHM_SNAP_W,
  parameter int DEPTH = fhm_pkg::FHM_DEPTH,
  parameter int SEL_W = fhm_pkg::FHM_SEL_W
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Capture side
  input wire logic push_in,
  input wire logic [WIDTH-1:0] push_data_in,
  // Read side
  input wire logic [SEL_W-1:0] rd_sel_in,
  output logic [WIDTH-1:0] rd_data_out
);
  import fhm_pkg::*;

  logic [WIDTH-1:0] entry_ff [DEPTH];
  logic [DEPTH-1:0] valid_ff;

  // Empty entries hold zeros, so an unused slot reads back as zero
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          entry_ff[gi] <= '0;
          valid_ff[gi] <= 1'b0;
        end else if (push_in) begin
          if (gi == 0) begin
            entry_ff[gi] <= push_data_in;
            valid_ff[gi] <= 1'b1;
          end else begin
            entry_ff[gi] <= entry_ff[gi-1];
            valid_ff[gi] <= valid_ff[gi-1];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_out <= '0;
    end else if (32'(rd_sel_in) < DEPTH && valid_ff[rd_sel_in]) begin
      rd_data_out <= entry_ff[rd_sel_in];
    end else begin
      rd_data_out <= '0;
    end
  end
endmodule : fhm_history_mem

// >>> core/fhm_counters.sv
module fhm_counters #(
  parameter int TICK_CYCLES = fhm_pkg::FHM_TICK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Position increments, reference units, signed
  input wire logic signed [15:0] ref_delta_in,
  input wire logic signed [15:0] fb_delta_in,
  // Counters
  output logic [31:0] power_on_time_out,
  output logic [31:0] position_error_out
);
  import fhm_pkg::*;

  logic [31:0] tick_ff;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tick_ff <= '0;
      power_on_time_out <= '0;
    end else if (tick_ff == 32'(TICK_CYCLES - 1)) begin
      tick_ff <= '0;
      power_on_time_out <= power_on_time_out + 32'h0000_0001;
    end else begin
      tick_ff <= tick_ff + 32'h0000_0001;
    end
  end

  // Wraps modulo 2^32 like the software view of the count
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      position_error_out <= '0;
    end else begin
      position_error_out <= position_error_out + 32'(ref_delta_in) - 32'(fb_delta_in);
    end
  end
endmodule : fhm_counters

// >>> bench/fhm_monitor_assertions.sv
module fhm_monitor_checker #(
  parameter int TICK_CYCLES = 4
) (
  // Clock, reset and APB
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  // Events
  input wire logic signed [15:0] ref_delta_in,
  input wire logic signed [15:0] fb_delta_in,
  input wire logic fault_in
);
  logic seen_ff;
  logic su;
  logic wr;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  assign su = psel_in && !penable_in && !pwrite_in;
  assign wr = psel_in && penable_in && pwrite_in;
  // Until the first fault every history field must read zero
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      seen_ff <= 1'b0;
    else if (fault_in)
      seen_ff <= 1'b1;
  end
  property p_time; su && paddr_in == 8'h00 ##2 su && paddr_in == 8'h00
    |=> prdata_out - $past(prdata_out, 2) <= 32'h1; endproperty
  a_time: assert property (p_time) else $error("power-on time jumped");
  property p_sel; wr && paddr_in == 8'h10 && pwdata_in <= 32'h9 ##1 su && paddr_in == 8'h10
    |=> prdata_out == $past(pwdata_in, 2); endproperty
  a_sel: assert property (p_sel) else $error("select not stored");
  property p_sel_max; su && paddr_in == 8'h10 |=> prdata_out <= 32'h9; endproperty
  a_sel_max: assert property (p_sel_max) else $error("select above nine");
  property p_empty; su && !seen_ff && paddr_in inside {[8'h14:8'h30]} |=> prdata_out == 0;
  endproperty
  a_empty: assert property (p_empty) else $error("empty entry not zero");
  property p_din; su && paddr_in == 8'h2c |=> prdata_out[31:5] == 27'h0; endproperty
  a_din: assert property (p_din) else $error("input levels too wide");
  property p_dout; su && paddr_in == 8'h30 |=> prdata_out[31:3] == 29'h0; endproperty
  a_dout: assert property (p_dout) else $error("output levels too wide");
  property p_pos; su && paddr_in == 8'h34 ##2 su && paddr_in == 8'h34
    |=> prdata_out == $past(prdata_out, 2) + 32'($past(ref_delta_in, 3))
      + 32'($past(ref_delta_in, 2)) - 32'($past(fb_delta_in, 3)) - 32'($past(fb_delta_in, 2));
  endproperty
  a_pos: assert property (p_pos) else $error("position error step wrong");
  c_fault: cover property (fault_in ##4 wr && paddr_in == 8'h10);
  c_sel: cover property (wr && paddr_in == 8'h10);
  c_pos: cover property (su && paddr_in == 8'h34);
endmodule : fhm_monitor_checker
bind fhm_monitor fhm_monitor_checker #(.TICK_CYCLES(TICK_CYCLES)) u_fhm_monitor_checker (
  .core_clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
  .prdata_out, .ref_delta_in, .fb_delta_in, .fault_in);

// >>> bench/fhm_monitor_tb.sv
module fhm_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [31:0] fhm_ent_t [8];
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, fault_in = 1'b0;
  logic pready_out, pslverr_out, err;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd, ex, pe_m, sel_m = 32'h0, ls = 32'h15;
  logic [15:0] phase_current_in = 16'h0, link_voltage_in = 16'h0, stage_temp_in = 16'h0;
  logic [15:0] motor_speed_in = 16'h0, current_u_in = 16'h0, current_v_in = 16'h0;
  logic [15:0] fault_code_in = 16'h0;
  logic signed [15:0] ref_delta_in = 16'h0, fb_delta_in = 16'h0;
  logic [4:0] digital_input_line_in = 5'h0;
  logic [2:0] digital_output_line_in = 3'h0;
  int cr, cyc, mismatches, comparisons;
  fhm_ent_t hq[$];
  fhm_monitor #(.TICK_CYCLES(4)) u_fhm_monitor (.core_clk_in, .sys_rst_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .phase_current_in, .link_voltage_in, .stage_temp_in, .motor_speed_in, .current_u_in,
    .current_v_in, .digital_input_line_in, .digital_output_line_in, .ref_delta_in,
    .fb_delta_in, .fault_in, .fault_code_in);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    repeat (32) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction : lfsr
  function automatic logic [31:0] expv(input logic [7:0] a);
    case (a) inside
      8'h00: return 32'(cr / 4);
      8'h04: return 32'(phase_current_in);
      8'h08: return 32'(link_voltage_in);
      8'h0c: return 32'(stage_temp_in);
      8'h10: return sel_m;
      [8'h14:8'h30]: return sel_m < hq.size() ? hq[sel_m][(a - 8'h14) / 4] : 32'h0;
      8'h34: return pe_m;
      default: return 32'h0;
    endcase
  endfunction : expv
  task automatic finish_test;
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Keep psel high only when the next setup follows at once
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic k);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    ex = expv(a);
    penable_in <= 1'b1;
    @(posedge core_clk_in);
    while (pready_out !== 1'b1) @(posedge core_clk_in);
    rd = prdata_out;
    err = pslverr_out;
    if (w && a == 8'h10 && d <= 32'h9) sel_m = d;
    penable_in <= 1'b0;
    if (!k) psel_in <= 1'b0;
  endtask : bus
  // Cycle count since release, divided by four and truncated, gives the power-on time
  task automatic rd_cmp(input logic [7:0] a, input logic k);
    bus(1'b0, a, 32'h0, k);
    chk(rd, ex);
  endtask : rd_cmp
  task automatic scan;
    for (int a = 0; a < 56; a += 4) rd_cmp(8'(a), a < 52);
  endtask : scan
  task automatic faults(input int n);
    repeat (n) begin
      fault_in <= 1'b1;
      @(posedge core_clk_in);
      fault_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
    end
  endtask : faults
  task automatic hist;
    for (int s = 0; s < 10; s++) begin
      bus(1'b1, 8'h10, 32'(s), 1'b0);
      @(posedge core_clk_in);
      for (int a = 20; a < 52; a += 4) rd_cmp(8'(a), a < 48);
      @(posedge core_clk_in);
    end
  endtask : hist
  always #20 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    ls = lfsr(ls);
    {phase_current_in, link_voltage_in} <= ls;
    ls = lfsr(ls);
    {stage_temp_in, motor_speed_in} <= ls;
    ls = lfsr(ls);
    {current_u_in, current_v_in} <= ls;
    ls = lfsr(ls);
    {fault_code_in, ref_delta_in} <= ls;
    ls = lfsr(ls);
    {fb_delta_in, digital_input_line_in, digital_output_line_in} <= ls[31:8];
  end
  // Whole run needs about 530 cycles
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc > 2000) begin
      mismatches++;
      finish_test();
    end
  end
  always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      cr <= 0;
      pe_m <= 32'h0;
      hq.delete();
    end else begin
      cr <= cr + 1;
      pe_m <= pe_m + 32'(ref_delta_in) - 32'(fb_delta_in);
      if (fault_in) begin
        hq.push_front('{fault_code_in, cr / 4, motor_speed_in, current_u_in, current_v_in,
          link_voltage_in, digital_input_line_in, digital_output_line_in});
        if (hq.size() > 10) hq.pop_back();
      end
    end
  end
  initial begin
    repeat (5) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    scan();
    @(posedge core_clk_in);
    bus(1'b0, 8'h38, 32'h0, 1'b1);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    bus(1'b1, 8'h00, 32'hffffffff, 1'b1);
    repeat (2) rd_cmp(8'h00, 1'b1);
    repeat (2) rd_cmp(8'h34, 1'b1);
    bus(1'b1, 8'h10, 32'h5, 1'b1);
    rd_cmp(8'h10, 1'b1);
    bus(1'b1, 8'h10, 32'h1a, 1'b1);
    rd_cmp(8'h10, 1'b1);
    bus(1'b1, 8'h10, 32'h0001_0003, 1'b1);
    rd_cmp(8'h10, 1'b0);
    faults(3);
    hist();
    faults(9);
    hist();
    sys_rst_in <= 1'b1;
    sel_m = 32'h0;
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    scan();
    finish_test();
  end
endmodule : fhm_monitor_tb
